/* File: bench/rcd_pad_model.sv */
// Pad model of the far side: folds a level and gate mode into the pin wire.
// Assumes level and gate come from flops on the same system clock.
`timescale 1ns/1ps
module rcd_pad_model (
  input wire logic clk,
  input wire logic oe,
  input wire rcd_pkg::rcd_clk_t drv,
  output logic wire_lvl
);
  logic float_q = 1'b0;

  ////////////////////////////////////////////////////////////////////////////
  // Released pad toggles, so a stale level can never pass for a match
  always @(posedge clk) begin
    float_q <= ~float_q;
  end

  // Gate mode decides how the source clock enters the wire
  always_comb begin
    if (!oe) begin
      wire_lvl = float_q;
    end else if (drv.gate == rcd_pkg::RCD_GATE_AND_SRC) begin
      wire_lvl = drv.level & clk;
    end else if (drv.gate == rcd_pkg::RCD_GATE_OR_SRC) begin
      wire_lvl = drv.level | clk;
    end else begin
      wire_lvl = drv.level;
    end
  end
endmodule

/* File: bench/tb_rcd_top.sv */
// Self-checking bench of the reference clock divider top.
// Assumes rcd_pkg and the design files are compiled ahead of it.
`timescale 1ns/1ps
module tb_rcd_top;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic sleep = 1'b0;
  logic [2:0] claim = 3'h0;
  logic qce_b = 1'b1;
  logic refclk_out_pin;
  rcd_pkg::rcd_gate_t pin_gate;
  logic pin_oe;
  logic slew;
  logic osc_sel;
  rcd_pkg::rcd_clk_t mod_clk;
  rcd_pkg::rcd_clk_t pin_drv;
  logic pin_wire;
  logic mod_wire;
  logic [7:0] v;
  int n_mismatch = 0;
  int cmp_count = 0;
  int cyc = 0;

  assign pin_drv = '{level: refclk_out_pin, gate: pin_gate};

  rcd_top dut_u (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sleep(sleep), .low_power_crystal_mode(claim[0]),
    .crystal_mode(claim[1]), .high_speed_crystal_mode(claim[2]), .quarter_clock_out_enable_b(qce_b),
    .refclk_out_pin(refclk_out_pin), .refclk_out_pin_gate(pin_gate), .refclk_out_pin_oe(pin_oe),
    .refclk_pin_slew_limit(slew), .osc_pin_input_select(osc_sel), .modulator_clk(mod_clk));
  rcd_pad_model pin_pad (.clk(clk), .oe(pin_oe), .drv(pin_drv), .wire_lvl(pin_wire));
  rcd_pad_model mod_pad (.clk(clk), .oe(1'b1), .drv(mod_clk), .wire_lvl(mod_wire));

  ////////////////////////////////////////////////////////////////////////////
  // Clock and hang guard; the ceiling is some sixteen times the expected run
  always #4 clk = ~clk;
  always @(posedge clk) begin
    cyc = cyc + 1;
    if (cyc == 40000) begin
      n_mismatch = n_mismatch + 1;
      complete_run();
    end
  end

  task automatic complete_run();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count = cmp_count + 1;
    if (seen !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %s: expected %h seen %h", what, exp, seen);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Register bus: one-cycle strobes, read data only in the following cycle
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    repeat (3) @(posedge clk);
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask

  function automatic logic [7:0] cfg(input logic en, input logic oe, input logic sl, input logic [1:0] duty,
    input logic [2:0] div);
    return {en, oe, sl, duty, div};
  endfunction

  // High samples over n cycles, from the pin or the modulator level
  task automatic count_hi(input int n, input logic pin, output logic [7:0] hi);
    hi = 8'h00;
    repeat (n) begin
      @(negedge clk);
      hi = hi + {7'h00, pin ? refclk_out_pin : mod_clk.level};
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset();
    rd(rcd_pkg::RCD_CTRL_ADDR, v);
    chk("ctrl", v, 8'h30);
    @(negedge clk);
    chk("rdata idle", reg_rdata, 8'h00);
    chk("slew", {7'h00, slew}, 8'h01);
    chk("pin oe", {7'h00, pin_oe}, 8'h00);
    chk("mod level", {7'h00, mod_clk.level}, 8'h00);
    rd(4'hF, v);
    chk("unmapped", v, 8'h00);
    wr(rcd_pkg::RCD_STAT_ADDR, 8'hFF);
    rd(rcd_pkg::RCD_STAT_ADDR, v);
    chk("status", v, 8'h00);
  endtask

  // Every divider above two with every duty code; windows are phase-free
  task automatic t_div_duty();
    int p;
    for (int d = 2; d < 8; d++) begin
      for (int u = 0; u < 4; u++) begin
        p = 1 << d;
        wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, u[1:0], d[2:0]));
        count_hi(p, 1'b0, v);
        chk("highs", v, 8'(p * u / 4));
        count_hi(p, 1'b1, v);
        chk("pin highs", v, 8'(p * u / 4));
      end
    end
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b0, 1'b1, 1'b1, 2'h2, 3'h3));
    count_hi(16, 1'b0, v);
    chk("disabled", v, 8'h00);
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b0, 1'b1, 2'h2, 3'h3));
    chk("pin oe off", {7'h00, pin_oe}, 8'h00);
  endtask

  // Undivided and divide-by-two shapes rely on the pad gate mode
  task automatic t_fast();
    for (int u = 1; u < 4; u++) begin
      wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, u[1:0], rcd_pkg::RCD_DIV_BASE));
      chk("base gate", 8'(mod_clk.gate), 8'(rcd_pkg::RCD_GATE_AND_SRC));
      @(posedge clk);
      #2;
      chk("base wire hi", {7'h00, mod_wire}, 8'h01);
      chk("base pin wire hi", {7'h00, pin_wire}, 8'h01);
      @(negedge clk);
      #1;
      chk("base wire lo", {7'h00, mod_wire}, 8'h00);
    end
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, rcd_pkg::RCD_DUTY_0, rcd_pkg::RCD_DIV_BASE));
    count_hi(6, 1'b0, v);
    chk("base zero", v, 8'h00);
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, rcd_pkg::RCD_DUTY_25, rcd_pkg::RCD_DIV_2));
    chk("half 25 gate", 8'(mod_clk.gate), 8'(rcd_pkg::RCD_GATE_AND_SRC));
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, rcd_pkg::RCD_DUTY_75, rcd_pkg::RCD_DIV_2));
    chk("half 75 gate", 8'(mod_clk.gate), 8'(rcd_pkg::RCD_GATE_OR_SRC));
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, rcd_pkg::RCD_DUTY_50, rcd_pkg::RCD_DIV_2));
    chk("half 50 gate", 8'(mod_clk.gate), 8'(rcd_pkg::RCD_GATE_LEVEL));
    count_hi(8, 1'b0, v);
    chk("half 50 highs", v, 8'h04);
  endtask

  // Crystal claims block the pin, quarter clock overrides it
  task automatic t_conflict();
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, 2'h2, 3'h3));
    for (int i = 0; i < 3; i++) begin
      @(posedge clk);
      claim <= 3'h1 << i;
      repeat (3) @(posedge clk);
      chk("osc select", {7'h00, osc_sel}, 8'h01);
      chk("pin oe", {7'h00, pin_oe}, 8'h00);
      count_hi(8, 1'b0, v);
      chk("mod highs", v, 8'h04);
    end
    rd(rcd_pkg::RCD_STAT_ADDR, v);
    chk("status osc", v, 8'h09);
    @(posedge clk);
    claim <= 3'h0;
    qce_b <= 1'b0;
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b1, rcd_pkg::RCD_DUTY_0, 3'h3));
    count_hi(8, 1'b1, v);
    chk("quarter highs", v, 8'h04);
    rd(rcd_pkg::RCD_STAT_ADDR, v);
    chk("status qtr", v, 8'h05);
    @(posedge clk);
    qce_b <= 1'b1;
  endtask

  task automatic t_slew_sleep();
    logic lv;
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b0, 2'h2, 3'h5));
    chk("slew off", {7'h00, slew}, 8'h00);
    repeat (10) @(posedge clk);
    sleep <= 1'b1;
    repeat (2) @(negedge clk);
    lv = mod_clk.level;
    count_hi(40, 1'b0, v);
    chk("sleep hold", v, lv ? 8'h28 : 8'h00);
    @(posedge clk);
    sleep <= 1'b0;
  endtask

  // Reset in mid-run brings defaults back and stops the generator
  task automatic t_midreset();
    wr(rcd_pkg::RCD_CTRL_ADDR, cfg(1'b1, 1'b1, 1'b0, 2'h2, 3'h2));
    rst_b <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    rd(rcd_pkg::RCD_CTRL_ADDR, v);
    chk("ctrl again", v, 8'h30);
    count_hi(8, 1'b0, v);
    chk("after reset", v, 8'h00);
    chk("slew again", {7'h00, slew}, 8'h01);
  endtask

  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    t_reset();
    t_div_duty();
    t_fast();
    t_conflict();
    t_slew_sleep();
    t_midreset();
    complete_run();
  end
endmodule

/* File: logic/rcd_divider.sv */
// Divider counter of the reference clock: counts 0 .. period-1.
// Assumes restart and run come from logic on the same clock.
`timescale 1ns/1ps
module rcd_divider (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic restart,
  input wire logic run,
  input wire logic [2:0] div,
  output logic [rcd_pkg::RCD_CNT_W-1:0] cnt_q
);

  logic [7:0] last;

  // Last count of the selected period
  assign last = rcd_pkg::rcd_period(div) - 8'h01;

  //////////////////////////////////////////////////////////////////////////////
  // Counter; holding while not running freezes phase through Sleep
  always_ff @(posedge clk) begin
    if (!rst_b || restart) begin
      cnt_q <= rcd_pkg::RCD_CNT_RESET;
    end else if (run) begin
      if ({1'b0, cnt_q} >= last) begin
        cnt_q <= rcd_pkg::RCD_CNT_RESET;
      end else begin
        cnt_q <= cnt_q + 7'h01;
      end
    end
  end

endmodule

/* File: logic/rcd_duty_shaper.sv */
// Duty shaper: turns the divider count into a level plus pad gating.
// Assumes the count never exceeds the period of the selected divider.
`timescale 1ns/1ps
module rcd_duty_shaper (
  input wire logic [2:0] div,
  input wire logic [1:0] duty,
  input wire logic [rcd_pkg::RCD_CNT_W-1:0] cnt,
  output rcd_pkg::rcd_clk_t shape
);

  logic [7:0] quarter;
  logic [7:0] thr;

  // High time in cycles for dividers of four and up
  assign quarter = rcd_pkg::rcd_period(div) >> 2;
  assign thr = quarter * {6'h00, duty};

  //////////////////////////////////////////////////////////////////////////////
  // Shape selection; sub-cycle duties borrow the source clock phase
  always_comb begin
    shape = rcd_pkg::RCD_CLK_LOW;
    if (duty == rcd_pkg::RCD_DUTY_0) begin
      shape = rcd_pkg::RCD_CLK_LOW;
    end else if (div == rcd_pkg::RCD_DIV_BASE) begin
      // Pad passes the source clock, so its own duty shows
      shape.level = 1'b1;
      shape.gate = rcd_pkg::RCD_GATE_AND_SRC;
    end else if (div == rcd_pkg::RCD_DIV_2) begin
      // Quarter steps need the falling edge: accuracy follows the source
      shape.level = (cnt == rcd_pkg::RCD_CNT_RESET);
      case (duty)
        rcd_pkg::RCD_DUTY_25: shape.gate = rcd_pkg::RCD_GATE_AND_SRC;
        rcd_pkg::RCD_DUTY_75: shape.gate = rcd_pkg::RCD_GATE_OR_SRC;
        default: shape.gate = rcd_pkg::RCD_GATE_LEVEL;
      endcase
    end else begin
      shape.level = ({1'b0, cnt} < thr);
    end
  end

endmodule

/* File: logic/rcd_pkg.sv */
// Package of the reference clock divider: control register layout,
// reset values, shaping modes and the divider period decode.
// Assumes a single 125 MHz system clock drives every user of it.
package rcd_pkg;

  //////////////////////////////////////////////////////////////////////////////
  // Register map and reset values
  localparam logic [3:0] RCD_CTRL_ADDR = 4'h0;
  localparam logic [3:0] RCD_STAT_ADDR = 4'h1;
  localparam logic [7:0] RCD_CTRL_RESET = 8'h30;
  localparam logic [7:0] RCD_RDATA_IDLE = 8'h00;

  // Control field positions, bit 7 down to bit 0
  localparam int RCD_EN_BIT = 7;
  localparam int RCD_OE_BIT = 6;
  localparam int RCD_SLEW_BIT = 5;
  localparam int RCD_DUTY_LO = 3;
  localparam int RCD_DIV_LO = 0;

  // Status field positions
  localparam int RCD_ST_RUN_BIT = 0;
  localparam int RCD_ST_REF_BIT = 1;
  localparam int RCD_ST_QTR_BIT = 2;
  localparam int RCD_ST_OSC_BIT = 3;

  //////////////////////////////////////////////////////////////////////////////
  // Field encodings
  localparam logic [1:0] RCD_DUTY_0 = 2'h0;
  localparam logic [1:0] RCD_DUTY_25 = 2'h1;
  localparam logic [1:0] RCD_DUTY_50 = 2'h2;
  localparam logic [1:0] RCD_DUTY_75 = 2'h3;
  localparam logic [2:0] RCD_DIV_BASE = 3'h0;
  localparam logic [2:0] RCD_DIV_2 = 3'h1;

  // Divider counter width, and divider and quarter-rate counter reset values
  localparam int RCD_CNT_W = 7;
  localparam logic [6:0] RCD_CNT_RESET = 7'h00;
  localparam logic [1:0] RCD_QTR_RESET = 2'h0;

  //////////////////////////////////////////////////////////////////////////////
  // Types
  typedef struct packed {
    logic enable;
    logic pin_oe;
    logic slew;
    logic [1:0] duty;
    logic [2:0] div;
  } rcd_ctrl_t;

  // How the pad combines a level with the raw source clock
  typedef enum logic [1:0] {
    RCD_GATE_LEVEL,
    RCD_GATE_AND_SRC,
    RCD_GATE_OR_SRC
  } rcd_gate_t;

  typedef struct packed {
    logic level;
    rcd_gate_t gate;
  } rcd_clk_t;

  localparam rcd_clk_t RCD_CLK_LOW = '{level: 1'b0, gate: RCD_GATE_LEVEL};

  // Divider period in system clock cycles: 1, 2, 4 .. 128
  function automatic logic [7:0] rcd_period(input logic [2:0] div);
    rcd_period = 8'h01 << div;
  endfunction

endpackage

/* File: logic/rcd_top.sv */
// Reference clock divider: control register, divider, duty shaper,
// and the shared output pin with its oscillator and quarter-clock claims.
// Assumes one 125 MHz system clock; configuration and sleep inputs come
// from logic on that clock, so none of them is synchronised here.
`timescale 1ns/1ps

// How it works
// - Reference clock comes only from system clock
// - Generator runs only while enable bit set
// - Pin driven only while pin output enabled or quarter clock claims it
// - Divider code selects divide by 1 to 128
// - Duty code gives 75, 50, 25, 0 percent
// - Undivided follows source duty, except zero percent
// - Divide-by-two quarter duties use both edges
// - Slew limit output follows its bit, resets set
// - Reset disables generator, restores register defaults
// - Crystal modes claim pin, block reference output
// - Quarter-rate clock out overrides reference clock
// - Reference pin needs clock-out config bit one
// - Modulator still gets clock when pin blocked
// - Sleep freezes generator and holds outputs
module rcd_top (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire logic sleep,
  input wire logic low_power_crystal_mode,
  input wire logic crystal_mode,
  input wire logic high_speed_crystal_mode,
  input wire logic quarter_clock_out_enable_b,
  output logic refclk_out_pin,
  output rcd_pkg::rcd_gate_t refclk_out_pin_gate,
  output logic refclk_out_pin_oe,
  output logic refclk_pin_slew_limit,
  output logic osc_pin_input_select,
  output rcd_pkg::rcd_clk_t modulator_clk
);

  //////////////////////////////////////////////////////////////////////////////
  // Declarations
  rcd_pkg::rcd_ctrl_t ctrl_q;
  logic [2:0] div_prev_q;
  logic en_prev_q;
  logic [1:0] qtr_cnt_q;
  logic [7:0] rdata_q;
  logic refclk_out_pin_q;
  rcd_pkg::rcd_gate_t pin_gate_q;
  logic pin_oe_q;
  logic slew_q;
  logic osc_sel_q;
  rcd_pkg::rcd_clk_t mod_clk_q;
  logic [rcd_pkg::RCD_CNT_W-1:0] cnt;
  rcd_pkg::rcd_clk_t shape;
  rcd_pkg::rcd_clk_t gen_d;
  logic osc_claim;
  logic qtr_claim;
  logic restart;
  logic run;
  logic qtr_level;
  logic [7:0] status;

  //////////////////////////////////////////////////////////////////////////////
  // Control register; any reset brings back the defaults
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_q <= rcd_pkg::RCD_CTRL_RESET;
    end else if (reg_wr && reg_addr == rcd_pkg::RCD_CTRL_ADDR) begin
      ctrl_q <= reg_wdata;
    end
  end

  // Read data stands for exactly the cycle after the strobe
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      rdata_q <= rcd_pkg::RCD_RDATA_IDLE;
    end else if (reg_rd) begin
      case (reg_addr)
        rcd_pkg::RCD_CTRL_ADDR: rdata_q <= ctrl_q;
        rcd_pkg::RCD_STAT_ADDR: rdata_q <= status;
        default: rdata_q <= rcd_pkg::RCD_RDATA_IDLE;
      endcase
    end else begin
      rdata_q <= rcd_pkg::RCD_RDATA_IDLE;
    end
  end

  // Status built from the enable bit and output flops plus the live sleep input and quarter-clock claim
  always_comb begin
    status = 8'h00;
    status[rcd_pkg::RCD_ST_RUN_BIT] = ctrl_q.enable && !sleep;
    status[rcd_pkg::RCD_ST_REF_BIT] = pin_oe_q && !qtr_claim;
    status[rcd_pkg::RCD_ST_QTR_BIT] = pin_oe_q && qtr_claim;
    status[rcd_pkg::RCD_ST_OSC_BIT] = osc_sel_q;
  end

  //////////////////////////////////////////////////////////////////////////////
  // Pin claims from the configuration word
  assign osc_claim = low_power_crystal_mode || crystal_mode || high_speed_crystal_mode;
  assign qtr_claim = !quarter_clock_out_enable_b;

  // Generator runs from the system clock only, and stops in Sleep
  assign run = ctrl_q.enable && !sleep;

  // Fresh period whenever enabled or the ratio moves
  assign restart = !ctrl_q.enable || !en_prev_q || (ctrl_q.div != div_prev_q);

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      div_prev_q <= rcd_pkg::RCD_CTRL_RESET[2:0];
      en_prev_q <= 1'b0;
    end else if (!sleep) begin
      div_prev_q <= ctrl_q.div;
      en_prev_q <= ctrl_q.enable;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Divider and shaper
  rcd_divider u_divider (
    .clk(clk),
    .rst_b(rst_b),
    .restart(restart),
    .run(run),
    .div(ctrl_q.div),
    .cnt_q(cnt)
  );

  rcd_duty_shaper u_shaper (
    .div(ctrl_q.div),
    .duty(ctrl_q.duty),
    .cnt(cnt),
    .shape(shape)
  );

  // Held low while disabled; follows the count in the same cycle
  assign gen_d = ctrl_q.enable ? shape : rcd_pkg::RCD_CLK_LOW;

  // Modulator feed ignores every pin conflict
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mod_clk_q <= rcd_pkg::RCD_CLK_LOW;
    end else if (!sleep) begin
      mod_clk_q <= gen_d;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Quarter-rate clock, high for two of four cycles
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      qtr_cnt_q <= rcd_pkg::RCD_QTR_RESET;
    end else if (!sleep) begin
      qtr_cnt_q <= qtr_cnt_q + 2'h1;
    end
  end

  assign qtr_level = !qtr_cnt_q[1];

  //////////////////////////////////////////////////////////////////////////////
  // Shared pin: oscillator first, then quarter clock, then reference
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      refclk_out_pin_q <= 1'b0;
      pin_gate_q <= rcd_pkg::RCD_GATE_LEVEL;
      pin_oe_q <= 1'b0;
      osc_sel_q <= 1'b0;
    end else if (!sleep) begin
      osc_sel_q <= osc_claim;
      if (osc_claim) begin
        refclk_out_pin_q <= 1'b0;
        pin_gate_q <= rcd_pkg::RCD_GATE_LEVEL;
        pin_oe_q <= 1'b0;
      end else if (qtr_claim) begin
        refclk_out_pin_q <= qtr_level;
        pin_gate_q <= rcd_pkg::RCD_GATE_LEVEL;
        pin_oe_q <= 1'b1;
      end else if (ctrl_q.enable && ctrl_q.pin_oe) begin
        refclk_out_pin_q <= gen_d.level;
        pin_gate_q <= gen_d.gate;
        pin_oe_q <= 1'b1;
      end else begin
        refclk_out_pin_q <= 1'b0;
        pin_gate_q <= rcd_pkg::RCD_GATE_LEVEL;
        pin_oe_q <= 1'b0;
      end
    end
  end

  // Slew limiting is harmless on a quiet pin, so it simply tracks its bit
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      slew_q <= rcd_pkg::RCD_CTRL_RESET[rcd_pkg::RCD_SLEW_BIT];
    end else if (!sleep) begin
      slew_q <= ctrl_q.slew;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Outputs, all straight from flops
  assign reg_rdata = rdata_q;
  assign refclk_out_pin = refclk_out_pin_q;
  assign refclk_out_pin_gate = pin_gate_q;
  assign refclk_out_pin_oe = pin_oe_q;
  assign refclk_pin_slew_limit = slew_q;
  assign osc_pin_input_select = osc_sel_q;
  assign modulator_clk = mod_clk_q;

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  property p_off_low;
    @(posedge clk) disable iff (!rst_b)
    (!ctrl_q.enable && !sleep) |=> !mod_clk_q.level;
  endproperty
  a_off_low: assert property (p_off_low) else $error("generator active while disabled");

  property p_pin_off;
    @(posedge clk) disable iff (!rst_b)
    (!ctrl_q.pin_oe && !qtr_claim && !sleep) |=> !pin_oe_q;
  endproperty
  a_pin_off: assert property (p_pin_off) else $error("pin driven without output enable");

  property p_cnt_range;
    @(posedge clk) disable iff (!rst_b)
    ({1'b0, cnt} < rcd_pkg::rcd_period(ctrl_q.div)) || restart;
  endproperty
  a_cnt_range: assert property (p_cnt_range) else $error("divider count beyond period");

  property p_div4_cycle;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_q.div == 3'h2 && ctrl_q.duty == rcd_pkg::RCD_DUTY_50 && !restart && !sleep
      && cnt == rcd_pkg::RCD_CNT_RESET)
    ##1 (ctrl_q.div == 3'h2 && ctrl_q.duty == rcd_pkg::RCD_DUTY_50 && !sleep && !restart)[*3]
    |-> !mod_clk_q.level ##1 !mod_clk_q.level ##1 mod_clk_q.level;
  endproperty
  a_div4_cycle: assert property (p_div4_cycle) else $error("divide by four half duty wrong");

  property p_zero_duty;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_q.duty == rcd_pkg::RCD_DUTY_0 && !sleep) |=> !mod_clk_q.level;
  endproperty
  a_zero_duty: assert property (p_zero_duty) else $error("zero duty not held low");

  property p_base_follow;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_q.enable && ctrl_q.div == rcd_pkg::RCD_DIV_BASE && ctrl_q.duty != rcd_pkg::RCD_DUTY_0 && !sleep)
    |=> mod_clk_q.level && mod_clk_q.gate == rcd_pkg::RCD_GATE_AND_SRC;
  endproperty
  a_base_follow: assert property (p_base_follow) else $error("undivided clock not passed");

  property p_div2_edges;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_q.enable && ctrl_q.div == rcd_pkg::RCD_DIV_2 && ctrl_q.duty == rcd_pkg::RCD_DUTY_75 && !sleep)
    |=> mod_clk_q.gate == rcd_pkg::RCD_GATE_OR_SRC;
  endproperty
  a_div2_edges: assert property (p_div2_edges) else $error("three quarter duty gating wrong");

  property p_slew;
    @(posedge clk) disable iff (!rst_b)
    !sleep |=> slew_q == $past(ctrl_q.slew);
  endproperty
  a_slew: assert property (p_slew) else $error("slew limit not following bit");

  property p_reset;
    @(posedge clk)
    !rst_b |=> ctrl_q == rcd_pkg::RCD_CTRL_RESET && !mod_clk_q.level && !pin_oe_q;
  endproperty
  a_reset: assert property (p_reset) else $error("reset did not restore defaults");

  property p_osc_block;
    @(posedge clk) disable iff (!rst_b)
    (osc_claim && !sleep) |=> !pin_oe_q && osc_sel_q;
  endproperty
  a_osc_block: assert property (p_osc_block) else $error("pin not yielded to oscillator");

  property p_qtr_wins;
    @(posedge clk) disable iff (!rst_b)
    (qtr_claim && !osc_claim && !sleep) |=> pin_oe_q && refclk_out_pin_q == $past(qtr_level);
  endproperty
  a_qtr_wins: assert property (p_qtr_wins) else $error("quarter clock not on pin");

  property p_mod_blocked;
    @(posedge clk) disable iff (!rst_b)
    (osc_claim && run && ctrl_q.div == rcd_pkg::RCD_DIV_BASE && ctrl_q.duty != rcd_pkg::RCD_DUTY_0)
    |=> mod_clk_q.level && !pin_oe_q;
  endproperty
  a_mod_blocked: assert property (p_mod_blocked) else $error("modulator lost clock on conflict");

  property p_sleep_hold;
    @(posedge clk) disable iff (!rst_b)
    sleep |=> $stable(mod_clk_q) && $stable(refclk_out_pin_q) && $stable(cnt);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) else $error("outputs moved during sleep");

  property p_restart;
    @(posedge clk) disable iff (!rst_b)
    restart |=> cnt == rcd_pkg::RCD_CNT_RESET;
  endproperty
  a_restart: assert property (p_restart) else $error("divider did not restart");

endmodule
